/* src/lev_params.svh */
`ifndef LEV_PARAMS_SVH
`define LEV_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define LEV_A_CFG    6'h02
`define LEV_A_INT    6'h03
`define LEV_A_ENL    6'h04
`define LEV_A_ENM    6'h05
`define LEV_A_ENT    6'h06
`define LEV_A_DIST   6'h07
`define LEV_A_TUNE   6'h08
`define LEV_A_CAL    6'h3d
`define LEV_CAL_CODE 8'h96

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define LEV_CFG_CLR  6
`define LEV_CFG_MIN  4
`define LEV_INT_DIV  6
`define LEV_INT_MASK 5
`define LEV_TD_ANT   7
`define LEV_TD_SYS   6
`define LEV_TD_TMR   5
`define LEV_SPIKE_REJECT_LEVEL_RST 4'h2
`define LEV_C_LTNG   3'h4
`define LEV_C_DIST   3'h2
`define LEV_C_NONE   3'h0
`define LEV_D_OUT    6'h3f
`define LEV_D_OVER   6'h01
`define LEV_DEPTH    16

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LEV_CLK_HZ   20000000
`define LEV_TMR_HZ   32768
`define LEV_TMR_HALF (`LEV_CLK_HZ / (2 * `LEV_TMR_HZ))
`define LEV_AGE_MIN  17
`define LEV_AGE_SEC  (`LEV_AGE_MIN * 60)
`endif

/* src/lev_pkg.sv */
package lev_pkg;
  typedef enum logic {LEV_LISTEN, LEV_VALIDATE} lev_mode_t;
  typedef enum logic [1:0] {LEV_CLR_IDLE, LEV_CLR_HIGH, LEV_CLR_LOW} lev_clr_t;
endpackage

/* src/lev_store_if.sv */
`timescale 1ns/1ps
interface lev_store_if;
  logic        push;
  logic [20:0] energy;
  logic        clear;
  logic        sec_tick;
  logic [5:0]  weight;
  logic [4:0]  count;
  logic        purge;
  modport ctrl  (output push, energy, clear, sec_tick, input weight, count, purge);
  modport store (input push, energy, clear, sec_tick, output weight, count, purge);
endinterface

/* src/lev_freq_div.sv */
`timescale 1ns/1ps
`include "lev_params.svh"
module lev_freq_div
  import lev_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ant_edge,
  input  wire logic [1:0] ratio_sel,
  output logic            div_out
);
  logic [6:0] cnt_reg;
  logic [6:0] half;
  logic       div_reg;

  // half period in antenna cycles: 8, 16, 32 or 64
  assign half    = 7'h08 << ratio_sel;
  assign div_out = div_reg;

  // ---------------------------------------------------------------
  // divider, advanced only on resonance edges
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= 7'h00;
      div_reg <= 1'b0;
    end else if (ant_edge) begin
      if (cnt_reg >= half - 7'h01) begin
        cnt_reg <= 7'h00;
        div_reg <= ~div_reg;
      end else begin
        cnt_reg <= cnt_reg + 7'h01;
      end
    end
  end

  a_div_on_edge: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(div_reg) |-> $past(ant_edge) && $past(cnt_reg) >= $past(half) - 7'h01)
    else $error("divider toggled without full count");
endmodule

/* src/lev_event_store.sv */
`timescale 1ns/1ps
`include "lev_params.svh"
module lev_event_store
  import lev_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  lev_store_if.store st
);
  logic [20:0] energy_mem [`LEV_DEPTH];
  logic [11:0] stamp_mem [`LEV_DEPTH];
  logic [15:0] vld_reg;
  logic [3:0]  wr_ptr_reg;
  logic [3:0]  scan_reg;
  logic [11:0] now_reg;
  logic        purge_reg;
  logic        hit;
  logic [11:0] age;

  // ---------------------------------------------------------------
  // seconds clock and event memory
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) now_reg <= 12'h000;
    else if (st.sec_tick) now_reg <= now_reg + 12'h001;
  end

  // wrap of the 12-bit stamp is safe: entries die long before it
  always_ff @(posedge ref_clk) begin
    if (st.push) begin
      energy_mem[wr_ptr_reg] <= st.energy;
      stamp_mem[wr_ptr_reg]  <= now_reg;
    end
  end

  assign age = now_reg - stamp_mem[scan_reg];
  assign hit = vld_reg[scan_reg] && age >= 12'(`LEV_AGE_SEC);

  // ---------------------------------------------------------------
  // valid bits: one entry checked for age each cycle
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || st.clear) begin
      vld_reg    <= 16'h0000;
      wr_ptr_reg <= 4'h0;
      purge_reg  <= 1'b0;
    end else begin
      purge_reg <= hit && !(st.push && wr_ptr_reg == scan_reg);
      if (hit) vld_reg[scan_reg] <= 1'b0;
      if (st.push) begin
        vld_reg[wr_ptr_reg] <= 1'b1;
        wr_ptr_reg          <= wr_ptr_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) scan_reg <= 4'h0;
    else scan_reg <= scan_reg + 4'h1;
  end

  // count of live events, strong ones weigh double
  always_comb begin
    st.count  = 5'h00;
    st.weight = 6'h00;
    for (int i = 0; i < `LEV_DEPTH; i++) begin
      st.count  = st.count + 5'(vld_reg[i]);
      st.weight = st.weight + 6'(vld_reg[i]) + 6'(vld_reg[i] & energy_mem[i][20]);
    end
  end
  assign st.purge = purge_reg;

  a_clear_all: assert property (@(posedge ref_clk) disable iff (rst)
    st.clear |=> st.count == 5'h00)
    else $error("statistics not erased");
endmodule

/* src/lev_event_logic.sv */
`timescale 1ns/1ps
`include "lev_params.svh"
module lev_event_logic
  import lev_pkg::*;
#(
  parameter int SEC_CYC = `LEV_CLK_HZ
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        sig_trigger,
  input  wire logic        val_done,
  input  wire logic [3:0]  val_score,
  input  wire logic [20:0] val_energy,
  input  wire logic        noise_high_pin,
  input  wire logic        antenna_pin,
  output logic             irq_pin,
  output logic      [3:0]  tune_caps,
  output logic             listening,
  output logic             osc_calibrate,
  output logic             calib_valid
);
  // ---------------------------------------------------------------
  // distance step table, indexed by weighted event count
  // ---------------------------------------------------------------
  function automatic logic [5:0] dist_lut(input logic [5:0] idx);
    case (idx)
      6'h00:   dist_lut = `LEV_D_OUT;
      6'h01:   dist_lut = 6'h28;
      6'h02:   dist_lut = 6'h25;
      6'h03:   dist_lut = 6'h22;
      6'h04:   dist_lut = 6'h1f;
      6'h05:   dist_lut = 6'h1b;
      6'h06:   dist_lut = 6'h18;
      6'h07:   dist_lut = 6'h14;
      6'h08:   dist_lut = 6'h11;
      6'h09:   dist_lut = 6'h0e;
      6'h0a:   dist_lut = 6'h0c;
      6'h0b:   dist_lut = 6'h0a;
      6'h0c:   dist_lut = 6'h08;
      6'h0d:   dist_lut = 6'h06;
      6'h0e:   dist_lut = 6'h05;
      default: dist_lut = `LEV_D_OVER;
    endcase
  endfunction

  // minimum lightning count per selection
  function automatic logic [4:0] min_count(input logic [1:0] sel);
    case (sel)
      2'b00:   min_count = 5'h01;
      2'b01:   min_count = 5'h05;
      2'b10:   min_count = 5'h09;
      default: min_count = 5'h10;
    endcase
  endfunction

  lev_store_if st ();

  logic [7:0]  cfg_reg;
  logic [2:0]  ictl_reg;
  logic [7:0]  td_reg;
  logic [2:0]  cause_reg;
  logic [20:0] energy_reg;
  logic [5:0]  dist_reg;
  logic        irq_level_reg;
  logic        irq_pin_reg;
  logic [7:0]  rdata_reg;
  logic        listen_reg;
  logic        cal_pulse_reg;
  logic        cal_valid_reg;
  lev_mode_t   mode_reg;
  lev_clr_t    clr_reg;
  logic [2:0]  noise_sync_reg;
  logic        noise_reg;
  logic [2:0]  ant_sync_reg;
  logic        ant_reg;
  logic        ant_edge;
  logic        ant_div;
  logic [8:0]  tmr_cnt_reg;
  logic        tmr_clk_reg;
  logic        sys_clk_reg;
  logic [24:0] sec_cnt_reg;
  logic        sec_tick_reg;
  logic        clr_pulse_reg;
  logic        ltng_evt;
  logic        dist_evt;
  logic        noise_rise;
  logic        purge_chg;
  logic        ltng_ok;
  logic        irq_set;
  logic [2:0]  cause_next;
  logic [4:0]  cnt_after;
  logic [5:0]  dist_next;
  logic        wr_cfg;
  logic        rd_int;

  assign wr_cfg = reg_wr && reg_addr == `LEV_A_CFG;
  assign rd_int = reg_rd && reg_addr == `LEV_A_INT;

  // ---------------------------------------------------------------
  // pin synchronisers: a change counts once stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      noise_sync_reg <= 3'h0;
      noise_reg      <= 1'b0;
      ant_sync_reg   <= 3'h0;
      ant_reg        <= 1'b0;
    end else begin
      noise_sync_reg <= {noise_sync_reg[1:0], noise_high_pin};
      ant_sync_reg   <= {ant_sync_reg[1:0], antenna_pin};
      if (noise_sync_reg[1] == noise_sync_reg[2]) noise_reg <= noise_sync_reg[2];
      if (ant_sync_reg[1] == ant_sync_reg[2]) ant_reg <= ant_sync_reg[2];
    end
  end

  assign noise_rise = (noise_sync_reg[1] == noise_sync_reg[2]) && noise_sync_reg[2] && !noise_reg;
  assign ant_edge   = (ant_sync_reg[1] == ant_sync_reg[2]) && ant_sync_reg[2] && !ant_reg;

  // ---------------------------------------------------------------
  // time base: seconds for ageing, timer oscillator image
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sec_cnt_reg  <= 25'h0;
      sec_tick_reg <= 1'b0;
    end else begin
      sec_tick_reg <= sec_cnt_reg == 25'(SEC_CYC - 1);
      if (sec_cnt_reg == 25'(SEC_CYC - 1)) sec_cnt_reg <= 25'h0;
      else sec_cnt_reg <= sec_cnt_reg + 25'h1;
    end
  end

  // timer oscillator rebuilt by division, so its image is only near 32.768 kHz
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tmr_cnt_reg <= 9'h000;
      tmr_clk_reg <= 1'b0;
      sys_clk_reg <= 1'b0;
    end else begin
      sys_clk_reg <= ~sys_clk_reg;
      if (tmr_cnt_reg == 9'(`LEV_TMR_HALF - 1)) begin
        tmr_cnt_reg <= 9'h000;
        tmr_clk_reg <= ~tmr_clk_reg;
      end else begin
        tmr_cnt_reg <= tmr_cnt_reg + 9'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_reg  <= {4'h0, `LEV_SPIKE_REJECT_LEVEL_RST};
      ictl_reg <= 3'h0;
      td_reg   <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `LEV_A_CFG) cfg_reg <= {1'b0, reg_wdata[6:0]};
      else if (reg_addr == `LEV_A_INT) ictl_reg <= reg_wdata[7:5];
      else if (reg_addr == `LEV_A_TUNE) td_reg <= {reg_wdata[7:5], 1'b0, reg_wdata[3:0]};
    end
  end

  // calibration result lives in flops only and is lost on reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cal_pulse_reg <= 1'b0;
      cal_valid_reg <= 1'b0;
    end else begin
      cal_pulse_reg <= reg_wr && reg_addr == `LEV_A_CAL && reg_wdata == `LEV_CAL_CODE;
      if (cal_pulse_reg) cal_valid_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // statistics clear: bit must go high, low, high
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clr_reg       <= LEV_CLR_IDLE;
      clr_pulse_reg <= 1'b0;
    end else begin
      clr_pulse_reg <= 1'b0;
      if (wr_cfg) begin
        case (clr_reg)
          LEV_CLR_IDLE: if (reg_wdata[`LEV_CFG_CLR]) clr_reg <= LEV_CLR_HIGH;
          LEV_CLR_HIGH: if (!reg_wdata[`LEV_CFG_CLR]) clr_reg <= LEV_CLR_LOW;
          LEV_CLR_LOW: begin
            if (reg_wdata[`LEV_CFG_CLR]) begin
              clr_reg       <= LEV_CLR_HIGH;
              clr_pulse_reg <= 1'b1;
            end
          end
          default: clr_reg <= LEV_CLR_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // listening / validating mode
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg   <= LEV_LISTEN;
      listen_reg <= 1'b1;
    end else begin
      case (mode_reg)
        LEV_LISTEN: begin
          if (sig_trigger) begin
            mode_reg   <= LEV_VALIDATE;
            listen_reg <= 1'b0;
          end
        end
        LEV_VALIDATE: begin
          if (val_done) begin
            mode_reg   <= LEV_LISTEN;
            listen_reg <= 1'b1;
          end
        end
        default: mode_reg <= LEV_LISTEN;
      endcase
    end
  end

  // a stricter spike level demands a better shape score
  assign ltng_evt = mode_reg == LEV_VALIDATE && val_done && val_score > cfg_reg[3:0];
  assign dist_evt = mode_reg == LEV_VALIDATE && val_done && val_score <= cfg_reg[3:0];

  // ---------------------------------------------------------------
  // event statistics
  // ---------------------------------------------------------------
  assign st.push     = ltng_evt;
  assign st.energy   = val_energy;
  assign st.clear    = clr_pulse_reg;
  assign st.sec_tick = sec_tick_reg;

  lev_event_store u_store (
    .ref_clk (ref_clk),
    .rst     (rst),
    .st      (st.store)
  );

  assign cnt_after = (st.count == 5'h10) ? 5'h10 : st.count + 5'h01;
  assign ltng_ok   = cnt_after >= min_count(cfg_reg[5:4]);
  assign dist_next = dist_lut((st.weight > 6'h0f) ? 6'h0f : st.weight);
  assign purge_chg = st.purge && dist_next != dist_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dist_reg   <= `LEV_D_OUT;
      energy_reg <= 21'h0;
    end else begin
      dist_reg <= dist_next;
      if (ltng_evt) energy_reg <= val_energy;
    end
  end

  // ---------------------------------------------------------------
  // interrupt cause and level
  // ---------------------------------------------------------------
  always_comb begin
    irq_set    = 1'b1;
    cause_next = cause_reg;
    if (ltng_evt && ltng_ok) begin
      cause_next = `LEV_C_LTNG;
    end else if (dist_evt && !ictl_reg[0]) begin
      cause_next = `LEV_C_DIST;
    end else if (noise_rise) begin
      cause_next = `LEV_C_NONE;
    end else if (purge_chg) begin
      cause_next = `LEV_C_NONE;
    end else begin
      irq_set = 1'b0;
    end
  end

  // a new event wins over an acknowledge in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cause_reg     <= `LEV_C_NONE;
      irq_level_reg <= 1'b0;
    end else begin
      cause_reg <= cause_next;
      if (irq_set) irq_level_reg <= 1'b1;
      else if (rd_int) irq_level_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pin: display clocks take precedence over interrupt level
  // ---------------------------------------------------------------
  lev_freq_div u_div (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ant_edge  (ant_edge),
    .ratio_sel (ictl_reg[2:1]),
    .div_out   (ant_div)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) irq_pin_reg <= 1'b0;
    else if (td_reg[`LEV_TD_ANT]) irq_pin_reg <= ant_div;
    else if (td_reg[`LEV_TD_SYS]) irq_pin_reg <= sys_clk_reg;
    else if (td_reg[`LEV_TD_TMR]) irq_pin_reg <= tmr_clk_reg;
    else irq_pin_reg <= irq_level_reg;
  end

  // ---------------------------------------------------------------
  // register reads, one cycle latency
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) rdata_reg <= 8'h00;
    else if (reg_rd) begin
      if (reg_addr == `LEV_A_CFG) rdata_reg <= cfg_reg;
      else if (reg_addr == `LEV_A_INT) rdata_reg <= {ictl_reg, 1'b0, cause_reg, noise_reg};
      else if (reg_addr == `LEV_A_ENL) rdata_reg <= energy_reg[7:0];
      else if (reg_addr == `LEV_A_ENM) rdata_reg <= energy_reg[15:8];
      else if (reg_addr == `LEV_A_ENT) rdata_reg <= {3'h0, energy_reg[20:16]};
      else if (reg_addr == `LEV_A_DIST) rdata_reg <= {2'h0, dist_reg};
      else if (reg_addr == `LEV_A_TUNE) rdata_reg <= td_reg;
      else rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata     = rdata_reg;
  assign irq_pin       = irq_pin_reg;
  assign tune_caps     = td_reg[3:0];
  assign listening     = listen_reg;
  assign osc_calibrate = cal_pulse_reg;
  assign calib_valid   = cal_valid_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_listen_return: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_reg == LEV_VALIDATE && val_done) |=> listen_reg ##1 listen_reg || mode_reg != LEV_LISTEN)
    else $error("no return to listening");

  a_energy_latch: assert property (@(posedge ref_clk) disable iff (rst)
    ltng_evt |=> energy_reg == $past(val_energy))
    else $error("energy not captured");

  a_ltng_cause: assert property (@(posedge ref_clk) disable iff (rst)
    (ltng_evt && ltng_ok) |=> cause_reg == `LEV_C_LTNG && irq_level_reg)
    else $error("lightning cause missing");

  a_noise_raise: assert property (@(posedge ref_clk) disable iff (rst)
    noise_rise |=> irq_level_reg && noise_reg)
    else $error("noise did not raise interrupt");

  a_disturber_mask: assert property (@(posedge ref_clk) disable iff (rst)
    (dist_evt && ictl_reg[0] && !noise_rise && !purge_chg) |=> !$rose(irq_level_reg))
    else $error("masked disturber raised interrupt");

  a_read_ack: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_int && !irq_set) |=> !irq_level_reg)
    else $error("cause read did not drop interrupt");

  a_min_count: assert property (@(posedge ref_clk) disable iff (rst)
    (ltng_evt && !ltng_ok && !noise_rise && !purge_chg) |=> !$rose(irq_level_reg))
    else $error("lightning irq below minimum count");

  a_pin_follow: assert property (@(posedge ref_clk) disable iff (rst)
    (td_reg[7:5] == 3'h0) |=> irq_pin_reg == $past(irq_level_reg))
    else $error("pin not following interrupt level");
endmodule

/* dv/lev_host_model.sv */
`timescale 1ns/1ps
// -----
// host side of the register port
// -----
module lev_host_model #(
  parameter int WAIT_CYC = 40000
)
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [5:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // port idle from time zero
  initial begin
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one-cycle strobe, address and data held across the taking edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk) #1;
    reg_wr = 1'b0;
  endtask

  // data is taken one edge after the strobe, where it has settled
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk) #1;
    reg_rd = 1'b0;
    @(posedge ref_clk) #1;
    d = reg_rdata;
  endtask

  // settle before the cause read, which also drops the pin
  task automatic ack(output logic [7:0] d);
    repeat (WAIT_CYC) @(posedge ref_clk);
    rd(6'h03, d);
  endtask

  // erase is a high, low, high sequence on the clear bit
  task automatic clr_stats(input logic [7:0] cfg);
    wr(6'h02, cfg | 8'h40);
    wr(6'h02, cfg & 8'hbf);
    wr(6'h02, cfg | 8'h40);
  endtask
endmodule

/* dv/lev_event_logic_tb.sv */
`timescale 1ns/1ps
`include "lev_params.svh"
module lev_event_logic_tb;
  // -----
  // bench signals
  // -----
  logic        ref_clk, rst, reg_wr, reg_rd, sig_trigger, val_done;
  logic        noise_high_pin, antenna_pin, ant_en;
  logic        irq_pin, listening, osc_calibrate, calib_valid;
  logic [5:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rv;
  logic [3:0]  val_score, tune_caps;
  logic [20:0] val_energy;
  int          miscompares, tests_run, cal_seen, tg;

  lev_event_logic #(.SEC_CYC(20)) dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sig_trigger(sig_trigger), .val_done(val_done), .val_score(val_score),
    .val_energy(val_energy), .noise_high_pin(noise_high_pin), .antenna_pin(antenna_pin),
    .irq_pin(irq_pin), .tune_caps(tune_caps), .listening(listening),
    .osc_calibrate(osc_calibrate), .calib_valid(calib_valid));
  lev_host_model #(.WAIT_CYC(40)) host (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // resonance wave, 400 ns, stands still unless displayed
  initial begin
    antenna_pin = 1'b0;
    #37;
    forever #200 antenna_pin = ant_en ? ~antenna_pin : antenna_pin;
  end
  // calibrate pulses are counted, a stuck strobe shows as many
  initial cal_seen = 0;
  always @(posedge ref_clk) if (osc_calibrate === 1'b1) cal_seen++;
  // hang guard, about three times the expected run
  initial begin
    #4000000;
    miscompares++;
    $display("[FAIL] watchdog expected done seen timeout");
    finish_test();
  end

  // -----
  // tasks
  // -----
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  // counts measured on free clocks carry a phase tolerance
  task automatic chkn(input string nm, input int e, input int g, input int tol);
    tests_run++;
    if (g < e - tol || g > e + tol) begin
      miscompares++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic chkrd(input logic [5:0] a, input logic [7:0] e, input string nm);
    host.rd(a, rv);
    chk8(nm, e, rv);
  endtask
  // one trigger and validation result
  task automatic ev(input logic [3:0] sc, input logic [20:0] en);
    @(posedge ref_clk) #1;
    sig_trigger = 1'b1;
    @(posedge ref_clk) #1;
    sig_trigger = 1'b0;
    chk1("listening_busy", 1'b0, listening);
    @(posedge ref_clk) #1;
    val_done = 1'b1;
    val_score = sc;
    val_energy = en;
    @(posedge ref_clk) #1;
    val_done = 1'b0;
    chk1("listening_back", 1'b1, listening);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic tog(input int n, output int c);
    logic p;
    c = 0;
    p = irq_pin;
    repeat (n) begin
      @(posedge ref_clk) #1;
      if (irq_pin !== p) c++;
      p = irq_pin;
    end
  endtask
  // clear, then n events; the pin may rise only on the last one
  task automatic minrun(input logic [1:0] mc, input int n, input logic [7:0] d);
    host.wr(`LEV_A_CFG, {2'b00, mc, 4'h2});
    host.clr_stats({2'b00, mc, 4'h2});
    host.rd(`LEV_A_INT, rv);
    chkrd(`LEV_A_DIST, 8'h3f, "dist_cleared");
    for (int i = 1; i <= n; i++) begin
      ev(4'h5, 21'h00100);
      chk1("irq_min_count", i == n, irq_pin);
    end
    chkrd(`LEV_A_DIST, d, "dist_table");
    host.ack(rv);
    chk8("cause_min_count", 8'h08, rv);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // -----
  // tests
  // -----
  initial begin
    rst = 1'b1;
    sig_trigger = 1'b0;
    val_done = 1'b0;
    val_score = 4'h0;
    val_energy = 21'h0;
    noise_high_pin = 1'b0;
    ant_en = 1'b0;
    miscompares = 0;
    tests_run = 0;
    repeat (12) @(posedge ref_clk);
    #1 rst = 1'b0;
    chkrd(`LEV_A_CFG, 8'h02, "spike_default");
    chkrd(`LEV_A_DIST, 8'h3f, "dist_reset");
    chkrd(6'h10, 8'h00, "unmapped");
    chk1("calib_reset", 1'b0, calib_valid);
    $display("test reset done");
    ev(4'h3, 21'h1abcde);
    chk1("irq_lightning", 1'b1, irq_pin);
    host.ack(rv);
    chk8("cause_lightning", 8'h08, rv);
    chk1("irq_ack", 1'b0, irq_pin);
    chkrd(`LEV_A_ENM, 8'hbc, "energy_mid");
    chkrd(`LEV_A_ENT, 8'h1a, "energy_top");
    chkrd(`LEV_A_DIST, 8'h25, "dist_two");
    ev(4'h2, 21'h0);
    chk1("irq_disturber", 1'b1, irq_pin);
    host.ack(rv);
    chk8("cause_disturber", 8'h04, rv);
    host.wr(`LEV_A_INT, 8'h20);
    ev(4'h0, 21'h0);
    chk1("irq_masked", 1'b0, irq_pin);
    host.wr(`LEV_A_INT, 8'h00);
    chkrd(`LEV_A_ENL, 8'hde, "energy_kept");
    $display("test events done");
    noise_high_pin = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 chk1("irq_noise", 1'b1, irq_pin);
    host.ack(rv);
    chk8("cause_noise", 8'h01, rv);
    chkrd(`LEV_A_INT, 8'h01, "noise_held");
    noise_high_pin = 1'b0;
    repeat (8) @(posedge ref_clk);
    chkrd(`LEV_A_INT, 8'h00, "noise_gone");
    $display("test noise done");
    minrun(2'b01, 5, 8'h1b);
    minrun(2'b10, 9, 8'h0e);
    minrun(2'b11, 16, 8'h01);
    $display("test statistics done");
    repeat (1030 * 20) @(posedge ref_clk);
    #1 chk1("irq_purge", 1'b1, irq_pin);
    host.ack(rv);
    chk8("cause_purge", 8'h00, rv);
    chkrd(`LEV_A_DIST, 8'h3f, "dist_aged");
    $display("test aging done");
    host.wr(`LEV_A_TUNE, 8'h45);
    chk8("tune_caps", 8'h05, {4'h0, tune_caps});
    tog(20, tg);
    chkn("sys_osc_toggles", 20, tg, 1);
    ant_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      host.wr(`LEV_A_INT, {k[1:0], 6'h00});
      host.wr(`LEV_A_TUNE, 8'h85);
      tog(1280, tg);
      chkn("antenna_toggles", 320 / (16 << k), tg, 1);
    end
    ant_en = 1'b0;
    ev(4'h0, 21'h0);
    host.wr(`LEV_A_TUNE, 8'h05);
    // pin flop still holds the divided clock for one edge after the write
    @(posedge ref_clk) #1;
    chk1("irq_restored", 1'b1, irq_pin);
    host.ack(rv);
    chk8("cause_ratio", 8'hc4, rv);
    $display("test display done");
    host.wr(`LEV_A_CAL, `LEV_CAL_CODE);
    repeat (3) @(posedge ref_clk);
    #1 chk1("calib_valid", 1'b1, calib_valid);
    chkn("cal_pulses", 1, cal_seen, 0);
    host.wr(`LEV_A_TUNE, 8'h25);
    tog(1220, tg);
    chkn("timer_toggles", 4, tg, 1);
    host.wr(`LEV_A_TUNE, 8'h05);
    $display("test calibration done");
    finish_test();
  end
endmodule
